// *** hex_char.sv ***
// converter of one binary nibble into an upper case ascii hex digit
`timescale 1ns/1ns
module hex_char (
   // digit in, character out
   hex_char_if.converter port_c
);
   import mirror_pkg::*;

   // =====================================================================
   // digits 0-9 map from 30h, letters A-F from 41h, always upper case
   always_comb begin
      if (port_c.nibble < NIBBLE_TEN) begin
         port_c.ascii = ASCII_ZERO + {4'h0, port_c.nibble};
      end else begin
         port_c.ascii = ASCII_LETTER + {4'h0, port_c.nibble};
      end
   end
endmodule

// *** hex_char_if.sv ***
// carrier between the mirror top and its hex character converter
`timescale 1ns/1ns
interface hex_char_if;
   logic [3:0]          nibble;   // binary digit to render
   mirror_pkg::byte_t   ascii;    // rendered character

   modport requester (output nibble, input ascii);
   modport converter (input nibble, output ascii);
endinterface

// *** mirror_monitor.sv ***
// checker of the mirror read path, watching the top ports only
`timescale 1ns/1ns
module mirror_monitor (
   input wire logic              SYS_CLK_I,
   input wire logic              SRST_I,
   input wire logic              CE_I,
   input wire logic [1:0]        MIRROR_SELECT_I,
   input wire logic [7:0]        MIRROR_PAGE_I,
   input wire logic              RD_VALID_I,
   input wire mirror_pkg::byte_t RD_DATA_I,
   input wire logic              RD_VALID_O,
   input wire mirror_pkg::byte_t RD_DATA_O,
   input wire logic              RD_MIRRORED_O,
   input wire logic              MIRROR_ACTIVE_O
);
   // one domain, so one clock and one disable for every property
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (SRST_I);
   property p_ans; CE_I && RD_VALID_I |=> RD_VALID_O; endproperty
   a_ans: assert property (p_ans) else $error("answer missing");
   property p_noans; CE_I && !RD_VALID_I |=> !RD_VALID_O; endproperty
   a_noans: assert property (p_noans) else $error("answer unasked");
   property p_off; CE_I && MIRROR_SELECT_I < 2'b10 |=> !MIRROR_ACTIVE_O; endproperty
   a_off: assert property (p_off) else $error("active while off");
   property p_low; CE_I && MIRROR_PAGE_I < 8'h04 |=> !MIRROR_ACTIVE_O; endproperty
   a_low: assert property (p_low) else $error("active below first page");
   // with the mirror off every byte is the stored one
   property p_echo;
      CE_I && RD_VALID_I && !MIRROR_SELECT_I[1]
         |=> !RD_MIRRORED_O && RD_DATA_O == $past(RD_DATA_I);
   endproperty
   a_echo: assert property (p_echo) else $error("stored byte altered");
   property p_hex;
      RD_VALID_O && RD_MIRRORED_O |-> RD_DATA_O inside {[8'h30:8'h39], [8'h41:8'h46], 8'h78};
   endproperty
   a_hex: assert property (p_hex) else $error("mirrored byte not hex");
   property p_cnt;
      CE_I && RD_VALID_I && MIRROR_SELECT_I == 2'b10 |=> !(RD_MIRRORED_O && RD_DATA_O == 8'h78);
   endproperty
   a_cnt: assert property (p_cnt) else $error("separator in counter mode");
   property p_hold; !CE_I |=> $stable(RD_DATA_O) && $stable(MIRROR_ACTIVE_O); endproperty
   a_hold: assert property (p_hold) else $error("output moved while frozen");
endmodule
bind uid_counter_ascii_mirror mirror_monitor mon (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I),
   .CE_I(CE_I), .MIRROR_SELECT_I(MIRROR_SELECT_I), .MIRROR_PAGE_I(MIRROR_PAGE_I),
   .RD_VALID_I(RD_VALID_I), .RD_DATA_I(RD_DATA_I), .RD_VALID_O(RD_VALID_O),
   .RD_DATA_O(RD_DATA_O), .RD_MIRRORED_O(RD_MIRRORED_O), .MIRROR_ACTIVE_O(MIRROR_ACTIVE_O));

// *** mirror_pkg.sv ***
// constants and types shared by the identifier and counter ascii mirror
// =====================================================================
// What this block does
// - mirror uid then counter as ascii text
// - insert separator 78h between uid and counter
// - combined mirror spans exactly 21 bytes
// - reads return mirrored bytes at mirrored positions
// - start at configured page and byte
// - combined mirror only when select is 11b
// - counter chars need authentication when guarded
// - no substitution if region passes memory end
// - select 10b mirrors counter only, six bytes
package mirror_pkg;
   // =====================================================================
   // mirror select encodings
   localparam logic [1:0] MODE_UID_CNT    = 2'b11;
   localparam logic [1:0] MODE_CNT_ONLY   = 2'b10;
   // =====================================================================
   // layout of the mirrored text
   localparam logic [7:0] SEPARATOR_CHAR  = 8'h78;
   localparam logic [9:0] UID_CHARS       = 10'h00E;
   localparam logic [9:0] CNT_CHARS       = 10'h006;
   localparam logic [9:0] COMBINED_LEN    = 10'h015;
   localparam logic [9:0] CNT_NIBBLE_BASE = 10'h00E;
   localparam logic [7:0] FIRST_USER_PAGE = 8'h04;
   localparam logic [7:0] LAST_USER_PAGE  = 8'h27;
   // latest combined start: this many pages below the last, at this byte
   localparam logic [7:0] COMBINED_TOP_GAP  = 8'h05;
   localparam logic [1:0] COMBINED_TOP_BYTE = 2'b10;
   // =====================================================================
   // hex digit to ascii
   localparam logic [7:0] ASCII_ZERO      = 8'h30;
   localparam logic [7:0] ASCII_LETTER    = 8'h37;
   localparam logic [3:0] NIBBLE_TEN      = 4'hA;
   // =====================================================================
   // reset values
   localparam logic [7:0] DATA_RESET      = 8'h00;

   typedef logic [7:0] byte_t;
   typedef logic [9:0] lin_addr_t;
endpackage

// *** reader_model.sv ***
// reader side model: stored user memory seen by each read request
`timescale 1ns/1ns
module reader_model (
   input  wire logic [7:0]  page_i,
   input  wire logic [1:0]  byte_i,
   output mirror_pkg::byte_t data_o
);
   import mirror_pkg::*;
   byte_t  mem [0:1023];   // random contents so an echo seldom looks like text
   integer seed = 30458;
   initial for (int i = 0; i < 1024; i++) mem[i] = 8'($random(seed));
   // stored bytes stay as written under the mirror
   assign data_o = mem[{page_i, byte_i}];
endmodule

// *** uid_counter_ascii_mirror.sv ***
// read path substitution of uid and counter ascii text into user memory
`timescale 1ns/1ns
module uid_counter_ascii_mirror #(
   parameter logic [7:0] LAST_PAGE = mirror_pkg::LAST_USER_PAGE  // last user page
) (
   // clock, reset, enable
   input  wire logic                SYS_CLK_I,
   input  wire logic                SRST_I,
   input  wire logic                CE_I,
   // mirror configuration
   input  wire logic [1:0]          MIRROR_SELECT_I,
   input  wire logic [7:0]          MIRROR_PAGE_I,
   input  wire logic [1:0]          MIRROR_BYTE_I,
   input  wire logic                COUNTER_AUTH_GUARD_I,
   input  wire logic                AUTH_DONE_I,
   // values to mirror
   input  wire logic [55:0]         UID_I,
   input  wire logic [23:0]         COUNTER_I,
   // read request with stored byte
   input  wire logic                RD_VALID_I,
   input  wire logic [7:0]          RD_PAGE_I,
   input  wire logic [1:0]          RD_BYTE_I,
   input  wire mirror_pkg::byte_t   RD_DATA_I,
   // read answer
   output logic                     RD_VALID_O,
   output mirror_pkg::byte_t        RD_DATA_O,
   output logic                     RD_MIRRORED_O,
   output logic                     MIRROR_ACTIVE_O
);
   import mirror_pkg::*;

   // =====================================================================
   // elaboration check: the combined text must fit above page 04h
   if (LAST_PAGE < FIRST_USER_PAGE + COMBINED_TOP_GAP) begin : g_last_page_check
      $error("LAST_PAGE too small for the combined mirror");
   end

   // =====================================================================
   // declarations
   hex_char_if  hex_bus ();                 // link to the converter
   lin_addr_t   start_addr;                 // first mirrored byte
   lin_addr_t   end_limit;                  // last user byte
   lin_addr_t   top_start;                  // latest legal combined start
   lin_addr_t   region_len;                 // length of active text
   lin_addr_t   rd_addr;                    // byte being read
   lin_addr_t   offset;                     // position inside text
   logic        mode_combined;              // select is 11b
   logic        mode_counter;               // select is 10b
   logic        range_ok;                   // start inside allowed window
   logic        fits;                       // text ends inside memory
   logic        active;                     // mirror in force
   logic        counter_ok;                 // counter may be shown
   logic        in_region;                  // read byte lies in text
   logic        is_sep;                     // read byte is the separator
   logic        is_cnt;                     // read byte is a counter char
   logic [9:0]  nibble_idx;                 // index into uid:counter digits
   logic [79:0] digits;                     // uid then counter, msb first
   logic [79:0] shifted;                    // digits moved to the top
   logic        next_mirrored;              // this byte gets replaced
   byte_t       next_data;                  // answer byte

   // =====================================================================
   // the converter renders the selected digit
   hex_char u_hex (
      .port_c (hex_bus.converter)
   );

   // =====================================================================
   // address arithmetic: page times four plus byte, ten bits wide
   always_comb begin
      start_addr = {MIRROR_PAGE_I, MIRROR_BYTE_I};
      end_limit  = {LAST_PAGE, 2'b11};
      top_start  = {LAST_PAGE - COMBINED_TOP_GAP, COMBINED_TOP_BYTE};
      rd_addr    = {RD_PAGE_I, RD_BYTE_I};
      offset     = rd_addr - start_addr;
   end

   // =====================================================================
   // mode decode and range checks
   always_comb begin
      mode_combined = (MIRROR_SELECT_I == MODE_UID_CNT);
      mode_counter  = (MIRROR_SELECT_I == MODE_CNT_ONLY);
      // combined text is 21 bytes, counter only text is 6
      region_len    = mode_combined ? COMBINED_LEN : CNT_CHARS;
      // a combined start at byte 11b of the top page would still fit, but
      // the permitted window stops at byte 10b there, so it is refused
      range_ok      = (MIRROR_PAGE_I >= FIRST_USER_PAGE) &&
                      (!mode_combined || (start_addr <= top_start));
      // for counter only text the end check sets the upper limit
      fits          = ({2'b00, start_addr} + {2'b00, region_len} - 12'h001)
                      <= {2'b00, end_limit};
      counter_ok    = !COUNTER_AUTH_GUARD_I || AUTH_DONE_I;
      // a guarded counter without authentication shows nothing at all
      // in counter only mode, since that mode has nothing else to show
      active        = range_ok && fits &&
                      (mode_combined || (mode_counter && counter_ok));
   end

   // =====================================================================
   // locate the read byte inside the text
   always_comb begin
      in_region = active && (rd_addr >= start_addr) && (offset < region_len);
      is_sep    = mode_combined && (offset[9:1] == UID_CHARS[9:1])
                  && !offset[0];
      is_cnt    = mode_counter || (offset > UID_CHARS);
      if (mode_combined) begin
         // skip the separator slot once past the identifier
         nibble_idx = (offset > UID_CHARS) ? offset - 10'h001 : offset;
      end else begin
         nibble_idx = CNT_NIBBLE_BASE + offset;
      end
   end

   // =====================================================================
   // pick the digit: uid in stored order, counter most significant first
   always_comb begin
      digits         = {UID_I, COUNTER_I};
      shifted        = digits << {nibble_idx[7:0], 2'b00};
      hex_bus.nibble = shifted[79:76];
   end

   // =====================================================================
   // choose between stored byte and mirrored character
   always_comb begin
      next_mirrored = 1'b0;
      next_data     = RD_DATA_I;
      if (in_region) begin
         if (is_sep) begin
            next_mirrored = 1'b1;
            next_data     = SEPARATOR_CHAR;
         end else if (is_cnt && !counter_ok) begin
            // guarded counter: the stored bytes show through
            next_mirrored = 1'b0;
            next_data     = RD_DATA_I;
         end else begin
            next_mirrored = 1'b1;
            next_data     = hex_bus.ascii;
         end
      end
   end

   // =====================================================================
   // answer register: one cycle after the request, frozen while ce low
   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         RD_VALID_O    <= 1'b0;
         RD_DATA_O     <= DATA_RESET;
         RD_MIRRORED_O <= 1'b0;
      end else if (CE_I) begin
         RD_VALID_O    <= RD_VALID_I;
         if (RD_VALID_I) begin
            RD_DATA_O     <= next_data;
            RD_MIRRORED_O <= next_mirrored;
         end
      end
   end

   // =====================================================================
   // status flag: shows whether the mirror is currently in force
   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         MIRROR_ACTIVE_O <= 1'b0;
      end else if (CE_I) begin
         MIRROR_ACTIVE_O <= active;
      end
   end
endmodule

// *** uid_counter_ascii_mirror_tb.sv ***
// self-checking bench of the uid and counter ascii mirror
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch %0t got %h exp %h", $time, a, b); end end
module uid_counter_ascii_mirror_tb;
   import mirror_pkg::*;
   localparam logic [7:0] LP = 8'h27;   // last user page
   logic clk = 0, rst = 1, ce = 1, guard = 0, auth = 0, rv = 0, vo, mo, act;
   logic [1:0] sel = 0, mbyte = 0, rb = 0;
   logic [7:0] mpage = 0, rp = 0;
   logic [55:0] uid = 56'h15_9D2A_6C3B_47E0;   // arbitrary identifier value
   logic [23:0] cnt = 24'h00_3F31;
   byte_t sd, dout;
   logic [8:0] q[$];   // expected {mirrored, byte} answers, oldest first
   logic [8:0] exp_ans;   // note taken off the queue for one answer
   int miscompares = 0, checks = 0, cyc = 0, seed = 30458;
   uid_counter_ascii_mirror #(.LAST_PAGE(LP)) dut (.SYS_CLK_I(clk), .SRST_I(rst), .CE_I(ce),
      .MIRROR_SELECT_I(sel), .MIRROR_PAGE_I(mpage), .MIRROR_BYTE_I(mbyte),
      .COUNTER_AUTH_GUARD_I(guard), .AUTH_DONE_I(auth), .UID_I(uid), .COUNTER_I(cnt),
      .RD_VALID_I(rv), .RD_PAGE_I(rp), .RD_BYTE_I(rb), .RD_DATA_I(sd), .RD_VALID_O(vo),
      .RD_DATA_O(dout), .RD_MIRRORED_O(mo), .MIRROR_ACTIVE_O(act));
   reader_model mem (.page_i(rp), .byte_i(rb), .data_o(sd));
   initial forever #50 clk = ~clk;
   function automatic byte_t hx(logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
   endfunction
   // mirror in force: valid start, fits, counter-only needs auth when guarded
   function automatic logic on();
      int st = mpage * 4 + mbyte;
      return sel[1] && mpage >= 8'h04 && st + (sel[0] ? 20 : 5) <= LP * 4 + 3
         && !(sel[0] && st > (LP - 5) * 4 + 2)
         && !(!sel[0] && guard && !auth);
   endfunction
   function automatic logic [8:0] ev(int a, byte_t s);
      int o = a - (mpage * 4 + mbyte);
      if (!on() || o < 0 || o > (sel[0] ? 20 : 5)) return {1'b0, s};
      if (!sel[0]) return {1'b1, hx(cnt[23 - 4 * o -: 4])};
      if (o < 14) return {1'b1, hx(uid[55 - 4 * o -: 4])};
      if (o == 14) return {1'b1, 8'h78};
      return (guard && !auth) ? {1'b0, s} : {1'b1, hx(cnt[23 - 4 * (o - 15) -: 4])};
   endfunction
   // configure, freeze a while, then read seven pages back to back
   task automatic run(logic [1:0] s, logic [7:0] p, logic [1:0] b, logic g, logic u);
      @(posedge clk) {sel, mpage, mbyte, guard, auth} <= {s, p, b, g, u};
      @(posedge clk) ce <= 0;
      repeat (3) @(posedge clk);
      ce <= 1;
      @(posedge clk) #1 `CHK(act, on())
      for (int a = p * 4; a < p * 4 + 28; a++) begin
         @(posedge clk) {rv, rp, rb} <= {1'b1, 10'(a)};
         #1 q.push_back(ev(a, sd));
      end
      @(posedge clk) rv <= 0;
      repeat (2) @(posedge clk);
   endtask
   task automatic summarize();
      if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // answers are compared where they have settled
   // the note is taken off once, so a mismatch cannot eat a second one
   always @(negedge clk) if (vo === 1'b1) begin
      exp_ans = q.pop_front();
      `CHK({mo, dout}, exp_ans)
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      for (int s = 0; s < 4; s++) run(2'(s), 8'h0C, 1, 0, 0);
      run(3, 8'h0C, 1, 1, 0);
      run(2, 8'h0C, 1, 1, 0);
      run(2, 8'h0C, 3, 1, 1);
      run(3, 8'h22, 2, 0, 0);
      run(3, 8'h22, 3, 0, 0);
      run(3, 8'h23, 0, 0, 0);
      run(3, 8'h03, 0, 0, 0);
      run(2, 8'h27, 0, 0, 0);
      repeat (4) begin
         {uid, cnt} <= 80'({$random(seed), $random(seed), $random(seed)});
         run(2'($random(seed)), 8'h04 + 8'($unsigned($random(seed)) % 31),
            2'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      end
      summarize();
   end
endmodule
